// ### logic/rfid_framing_consts.vh
// register map, reset values and timing constants of the reader framing block
`ifndef RFID_FRAMING_CONSTS_VH
`define RFID_FRAMING_CONSTS_VH
// register byte addresses
`define OFS_CTRL        6'h00
`define OFS_BAUD        6'h04
`define OFS_HOLD        6'h08
`define OFS_MAXTAGS     6'h0C
`define OFS_REREAD      6'h10
`define OFS_CHAN        6'h14
`define OFS_ANT         6'h18
`define OFS_USTART      6'h1C
`define OFS_ULEN        6'h20
`define OFS_TIDLEN      6'h24
`define OFS_STATUS      6'h28
`define OFS_RXDATA      6'h2C
// control field positions
`define CTRL_LFCR_BIT   0
`define CTRL_FILT_BIT   1
`define CTRL_PAR_LO     2
`define CTRL_PAR_HI     3
`define CTRL_EPCL_BIT   4
// reset values
`define CTRL_RST        5'h00
`define CLK_HZ          250000000
`define BAUD_DEFAULT    115200
`define BAUD_DIV_RST    16'h087A
`define HOLD_RST        8'h05
`define MAXTAGS_RST     10'h080
`define REREAD_RST      8'h05
`define CHAN_RST        16'h0008
`define ANT_RST         4'h1
`define USTART_RST      16'h0000
`define ULEN_RST        5'h10
`define ULEN_MIN        5'h01
`define TIDLEN_RST      4'hC
`define TIDLEN_MIN      4'h2
// epc field widths in bytes
`define EPC_ADDR_SHORT  6'h10
`define EPC_ADDR_LONG   6'h3E
`define EPC_BLK_SHORT   6'h0C
`define EPC_BLK_LONG    6'h3E
// characters and status numbers
`define CH_ACK          8'h06
`define CH_NAK          8'h15
`define CH_LF           8'h0A
`define CH_CR           8'h0D
`define NAK_CRC         8'h01
`define NAK_NOTAG       8'h02
`define NAK_PARITY      8'h03
// timing
`define HOLD_UNIT_S     1
`define DWELL_TIME_US   1000
`define GAP_BITS        8'h14
`endif

// ### logic/rfid_framing.v
// reader host link framing, acknowledge and reader parameter set
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "rfid_framing_consts.vh"
module rfid_framing #(
    parameter SEC_CYCLES   = `CLK_HZ * `HOLD_UNIT_S,
    parameter DWELL_CYCLES = (`CLK_HZ / 1000000) * `DWELL_TIME_US
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        reset,
    // avalon-mm slave
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // serial host link
    input  wire        uart_rxd,
    output wire        uart_txd,
    // telegram events
    output reg         cmd_good,
    output reg         cmd_bad,
    // antenna and channel
    output reg  [3:0]  ant_select,
    output wire [3:0]  ant_power,
    output reg  [3:0]  chan_index,
    // tag events from the air side
    input  wire        tag_read_ok,
    input  wire        tag_read_fail,
    input  wire [3:0]  tag_tid_len,
    input  wire        tag_epc_long,
    input  wire        tag_dup,
    // tag results
    output reg         tag_present,
    output reg         tag_arrive,
    output reg         tag_depart,
    output reg         tag_report,
    // user start and field lengths for the command decoder
    output reg  [15:0] user_start,
    output reg  [4:0]  user_len,
    output reg  [3:0]  tid_len,
    output reg  [5:0]  epc_addr_bytes,
    output reg  [5:0]  epc_blk_bytes
);

    function [15:0] crc_step;
        input [15:0] c;
        input [7:0]  d;
        integer      i;
        reg   [15:0] t;
        begin
            t = c;
            for (i = 7; i >= 0; i = i - 1)
            begin
                if (t[15] ^ d[i])
                    t = {t[14:0], 1'b0} ^ 16'h1021;
                else
                    t = {t[14:0], 1'b0};
            end
            crc_step = t;
        end
    endfunction

    reg [4:0]  ctrl_r;
    reg [15:0] baud_r;
    reg [7:0]  hold_r;
    reg [9:0]  maxtags_r;
    reg [7:0]  reread_r;
    reg [15:0] chan_en_r;
    reg [3:0]  ant_en_r;
    reg [7:0]  rx_byte_r;
    reg        rx_avail_r;
    reg        ack_r;
    wire       term_lfcr = ctrl_r[`CTRL_LFCR_BIT];
    wire       filt_en   = ctrl_r[`CTRL_FILT_BIT];
    wire [1:0] par_mode  = ctrl_r[`CTRL_PAR_HI:`CTRL_PAR_LO];
    wire       epc_long  = ctrl_r[`CTRL_EPCL_BIT];
    wire       wr_hit    = avs_write & ack_r;
    wire       rd_hit    = avs_read & ack_r;
    wire [5:0] reg_addr  = {avs_address[5:2], 2'b00};
    wire       rx_pop    = rd_hit & (reg_addr == `OFS_RXDATA);
    reg        rx_push;

    // bus slave: one wait cycle, then the access completes
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            ack_r          <= 1'b0;
            avs_readdata   <= 32'h00000000;
            ctrl_r         <= `CTRL_RST;
            baud_r         <= `BAUD_DIV_RST;
            hold_r         <= `HOLD_RST;
            maxtags_r      <= `MAXTAGS_RST;
            reread_r       <= `REREAD_RST;
            chan_en_r      <= `CHAN_RST;
            ant_en_r       <= `ANT_RST;
            user_start     <= `USTART_RST;
            user_len       <= `ULEN_RST;
            tid_len        <= `TIDLEN_RST;
            epc_addr_bytes <= `EPC_ADDR_SHORT;
            epc_blk_bytes  <= `EPC_BLK_SHORT;
        end
        else
        begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
            if (wr_hit)
            begin
                case (reg_addr)
                    `OFS_CTRL:    ctrl_r <= avs_writedata[4:0];
                    `OFS_BAUD:    baud_r <= (avs_writedata[15:0] < 16'h0010) ? 16'h0010
                                            : avs_writedata[15:0];
                    `OFS_HOLD:    hold_r <= avs_writedata[7:0];
                    `OFS_MAXTAGS: maxtags_r <= avs_writedata[9:0];
                    `OFS_REREAD:  reread_r <= avs_writedata[7:0];
                    `OFS_CHAN:    chan_en_r <= avs_writedata[15:0];
                    `OFS_ANT:     ant_en_r <= avs_writedata[3:0];
                    `OFS_USTART:  user_start <= avs_writedata[15:0];
                    `OFS_ULEN:    user_len <= (avs_writedata[4:0] < `ULEN_MIN) ? `ULEN_MIN
                                              : (avs_writedata[4:0] > `ULEN_RST) ? `ULEN_RST
                                              : avs_writedata[4:0];
                    `OFS_TIDLEN:  tid_len <= (avs_writedata[3:0] < `TIDLEN_MIN) ? `TIDLEN_MIN
                                             : (avs_writedata[3:0] > `TIDLEN_RST) ? `TIDLEN_RST
                                             : avs_writedata[3:0];
                    default:      ;
                endcase
            end
            epc_addr_bytes <= epc_long ? `EPC_ADDR_LONG : `EPC_ADDR_SHORT;
            epc_blk_bytes  <= epc_long ? `EPC_BLK_LONG : `EPC_BLK_SHORT;
            if (avs_read & ~ack_r)
            begin
                case (reg_addr)
                    `OFS_CTRL:    avs_readdata <= {27'h0, ctrl_r};
                    `OFS_BAUD:    avs_readdata <= {16'h0, baud_r};
                    `OFS_HOLD:    avs_readdata <= {24'h0, hold_r};
                    `OFS_MAXTAGS: avs_readdata <= {22'h0, maxtags_r};
                    `OFS_REREAD:  avs_readdata <= {24'h0, reread_r};
                    `OFS_CHAN:    avs_readdata <= {16'h0, chan_en_r};
                    `OFS_ANT:     avs_readdata <= {28'h0, ant_en_r};
                    `OFS_USTART:  avs_readdata <= {16'h0, user_start};
                    `OFS_ULEN:    avs_readdata <= {27'h0, user_len};
                    `OFS_TIDLEN:  avs_readdata <= {28'h0, tid_len};
                    `OFS_STATUS:  avs_readdata <= {20'h00000, chan_index, ant_select,
                                                       2'b00, (ant_power != 4'h0), tag_present};
                    `OFS_RXDATA:  avs_readdata <= {23'h0, rx_avail_r, rx_byte_r};
                    default:      avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // receive: three-flop pin synchroniser, change taken when last two agree
    reg rxd_s1_r, rxd_s2_r, rxd_s3_r, rxd_r;
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            rxd_s1_r <= 1'b1;
            rxd_s2_r <= 1'b1;
            rxd_s3_r <= 1'b1;
            rxd_r    <= 1'b1;
        end
        else
        begin
            rxd_s1_r <= uart_rxd;
            rxd_s2_r <= rxd_s1_r;
            rxd_s3_r <= rxd_s2_r;
            if (rxd_s2_r == rxd_s3_r)
                rxd_r <= rxd_s3_r;
        end
    end

    localparam RX_IDLE = 5'b00001;
    localparam RX_STRT = 5'b00010;
    localparam RX_DATA = 5'b00100;
    localparam RX_PAR  = 5'b01000;
    localparam RX_STOP = 5'b10000;
    reg [4:0]  rx_st_r;
    reg [15:0] rx_cnt_r;
    reg [2:0]  rx_bit_r;
    reg [7:0]  rx_sh_r;
    reg        rx_perr_r;
    reg        frm_perr_r;
    reg [7:0]  gap_r;
    reg [7:0]  prev_r;
    reg        in_frame_r;
    reg [15:0] rx_crc_r;
    reg        frm_end;
    reg        frm_ok;
    reg [7:0]  frm_stat;
    wire       rx_tick   = (rx_cnt_r == 16'h0000);
    wire       par_calc  = ^rx_sh_r ^ par_mode[1];

    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            rx_st_r    <= RX_IDLE;
            rx_cnt_r   <= 16'h0000;
            rx_bit_r   <= 3'h0;
            rx_sh_r    <= 8'h00;
            rx_perr_r  <= 1'b0;
            rx_push    <= 1'b0;
        end
        else
        begin
            rx_push  <= 1'b0;
            rx_cnt_r <= rx_tick ? baud_r - 16'h0001 : rx_cnt_r - 16'h0001;
            case (rx_st_r)
                RX_IDLE:
                    if (!rxd_r)
                    begin
                        rx_st_r  <= RX_STRT;
                        rx_cnt_r <= {1'b0, baud_r[15:1]};
                    end
                RX_STRT:
                    if (rx_tick)
                    begin
                        rx_st_r   <= rxd_r ? RX_IDLE : RX_DATA;
                        rx_bit_r  <= 3'h0;
                        rx_perr_r <= 1'b0;
                    end
                RX_DATA:
                    if (rx_tick)
                    begin
                        rx_sh_r  <= {rxd_r, rx_sh_r[7:1]};
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == 3'h7)
                            rx_st_r <= (par_mode == 2'b00) ? RX_STOP : RX_PAR;
                    end
                RX_PAR:
                    if (rx_tick)
                    begin
                        rx_perr_r <= (rxd_r != par_calc);
                        rx_st_r   <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_tick)
                    begin
                        rx_st_r <= RX_IDLE;
                        rx_push <= rxd_r;
                    end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // telegram end: lf cr pair, or an idle gap when the crc closes it
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            gap_r      <= 8'h00;
            prev_r     <= 8'h00;
            in_frame_r <= 1'b0;
            rx_crc_r   <= 16'h0000;
            frm_perr_r <= 1'b0;
            rx_byte_r  <= 8'h00;
            rx_avail_r <= 1'b0;
            frm_end    <= 1'b0;
            frm_ok     <= 1'b0;
            frm_stat   <= 8'h00;
        end
        else
        begin
            frm_end <= 1'b0;
            if (rx_push)
            begin
                rx_byte_r  <= rx_sh_r;
                rx_avail_r <= 1'b1;
                prev_r     <= rx_sh_r;
                gap_r      <= 8'h00;
                in_frame_r <= 1'b1;
                frm_perr_r <= frm_perr_r | rx_perr_r;
                rx_crc_r   <= crc_step(rx_crc_r, rx_sh_r);
                if (term_lfcr && prev_r == `CH_LF && rx_sh_r == `CH_CR)
                begin
                    frm_end    <= 1'b1;
                    frm_ok     <= ~(frm_perr_r | rx_perr_r);
                    frm_stat   <= `NAK_PARITY;
                    in_frame_r <= 1'b0;
                    frm_perr_r <= 1'b0;
                    rx_crc_r   <= 16'h0000;
                    prev_r     <= 8'h00;
                end
            end
            else
            begin
                if (rx_pop)
                    rx_avail_r <= 1'b0;
                if (in_frame_r && (rx_st_r == RX_IDLE) && rx_tick)
                    gap_r <= gap_r + 8'h01;
                if (in_frame_r && !term_lfcr && gap_r == `GAP_BITS)
                begin
                    // crc over payload plus its own two bytes leaves zero
                    frm_end    <= 1'b1;
                    frm_ok     <= (rx_crc_r == 16'h0000) & ~frm_perr_r;
                    frm_stat   <= frm_perr_r ? `NAK_PARITY : `NAK_CRC;
                    in_frame_r <= 1'b0;
                    frm_perr_r <= 1'b0;
                    rx_crc_r   <= 16'h0000;
                    prev_r     <= 8'h00;
                end
            end
        end
    end

    // reply: ack or nak plus status, then the selected termination
    localparam TX_IDLE = 5'b00001;
    localparam TX_HEAD = 5'b00010;
    localparam TX_STAT = 5'b00100;
    localparam TX_END1 = 5'b01000;
    localparam TX_END2 = 5'b10000;
    reg [4:0]  rp_st_r;
    reg [7:0]  rp_stat_r;
    reg        rp_nak_r;
    reg [15:0] tx_crc_r;
    reg [10:0] tx_sh_r;
    reg [3:0]  tx_left_r;
    reg [15:0] tx_cnt_r;
    reg [7:0]  tx_byte;
    wire       tx_free = (tx_left_r == 4'h0);
    wire       tx_par  = ^tx_byte ^ par_mode[1];

    always @*
    begin
        tx_byte = 8'h00;
        case (rp_st_r)
            TX_HEAD: tx_byte = rp_nak_r ? `CH_NAK : `CH_ACK;
            TX_STAT: tx_byte = rp_stat_r;
            TX_END1: tx_byte = term_lfcr ? `CH_LF : tx_crc_r[15:8];
            TX_END2: tx_byte = term_lfcr ? `CH_CR : tx_crc_r[7:0];
            default: tx_byte = 8'h00;
        endcase
    end

    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            rp_st_r   <= TX_IDLE;
            rp_stat_r <= 8'h00;
            rp_nak_r  <= 1'b0;
            tx_crc_r  <= 16'h0000;
            tx_sh_r   <= 11'h7FF;
            tx_left_r <= 4'h0;
            tx_cnt_r  <= 16'h0000;
            cmd_good  <= 1'b0;
            cmd_bad   <= 1'b0;
        end
        else
        begin
            cmd_good <= frm_end & frm_ok;
            cmd_bad  <= frm_end & ~frm_ok;
            if (!tx_free)
            begin
                tx_cnt_r <= (tx_cnt_r == 16'h0000) ? baud_r - 16'h0001 : tx_cnt_r - 16'h0001;
                if (tx_cnt_r == 16'h0000)
                begin
                    tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
                    tx_left_r <= tx_left_r - 4'h1;
                end
            end
            case (rp_st_r)
                TX_IDLE:
                    if (frm_end)
                    begin
                        rp_nak_r  <= ~(frm_ok & tag_present);
                        rp_stat_r <= frm_ok ? `NAK_NOTAG : frm_stat;
                        tx_crc_r  <= 16'h0000;
                        rp_st_r   <= TX_HEAD;
                    end
                TX_HEAD, TX_STAT, TX_END1, TX_END2:
                    if (tx_free)
                    begin
                        tx_cnt_r  <= baud_r - 16'h0001;
                        if (par_mode == 2'b00)
                        begin
                            tx_sh_r   <= {2'b11, tx_byte, 1'b0};
                            tx_left_r <= 4'hA;
                        end
                        else
                        begin
                            tx_sh_r   <= {1'b1, tx_par, tx_byte, 1'b0};
                            tx_left_r <= 4'hB;
                        end
                        if (rp_st_r == TX_HEAD || rp_st_r == TX_STAT)
                            tx_crc_r <= crc_step(tx_crc_r, tx_byte);
                        case (rp_st_r)
                            TX_HEAD: rp_st_r <= rp_nak_r ? TX_STAT : TX_END1;
                            TX_STAT: rp_st_r <= TX_END1;
                            TX_END1: rp_st_r <= TX_END2;
                            default: rp_st_r <= TX_IDLE;
                        endcase
                    end
                default: rp_st_r <= TX_IDLE;
            endcase
        end
    end
    assign uart_txd = tx_sh_r[0];

    // antenna round robin, channel hop and hold timer
    reg [27:0] dwell_r;
    reg [27:0] sec_r;
    reg [7:0]  hold_left_r;
    reg [9:0]  tag_cnt_r;
    reg [3:0]  chan_nxt;
    integer    k;
    always @*
    begin
        chan_nxt = chan_index;
        for (k = 15; k >= 1; k = k - 1)
            if (chan_en_r[chan_index + k[3:0]])
                chan_nxt = chan_index + k[3:0];
    end
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            dwell_r     <= 28'h0000000;
            sec_r       <= 28'h0000000;
            hold_left_r <= 8'h00;
            ant_select  <= 4'h1;
            chan_index  <= 4'h3;
        end
        else
        begin
            dwell_r <= dwell_r + 28'h0000001;
            if (dwell_r == DWELL_CYCLES[27:0] - 28'h0000001)
            begin
                dwell_r    <= 28'h0000000;
                ant_select <= {ant_select[2:0], ant_select[3]};
                chan_index <= chan_nxt;
            end
            sec_r <= sec_r + 28'h0000001;
            if (cmd_good)
            begin
                hold_left_r <= hold_r;
                sec_r       <= 28'h0000000;
            end
            else if (sec_r == SEC_CYCLES[27:0] - 28'h0000001)
            begin
                sec_r <= 28'h0000000;
                if (hold_left_r != 8'h00)
                    hold_left_r <= hold_left_r - 8'h01;
            end
        end
    end
    assign ant_power = (hold_left_r != 8'h00) ? (ant_en_r & ant_select) : 4'h0;

    // tag acceptance, presence debounce and report cap
    reg  [7:0] hit_r;
    reg  [7:0] miss_r;
    wire       tag_ok = (tag_tid_len == tid_len) & (epc_long | ~tag_epc_long);
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            hit_r       <= 8'h00;
            miss_r      <= 8'h00;
            tag_present <= 1'b0;
            tag_arrive  <= 1'b0;
            tag_depart  <= 1'b0;
            tag_report  <= 1'b0;
            tag_cnt_r   <= 10'h000;
        end
        else
        begin
            tag_arrive <= 1'b0;
            tag_depart <= 1'b0;
            tag_report <= 1'b0;
            if (cmd_good)
                tag_cnt_r <= 10'h000;
            else if (tag_read_ok && tag_ok)
            begin
                miss_r <= 8'h00;
                if (!tag_present)
                begin
                    hit_r <= hit_r + 8'h01;
                    if (hit_r + 8'h01 >= reread_r)
                    begin
                        tag_present <= 1'b1;
                        tag_arrive  <= 1'b1;
                        hit_r       <= 8'h00;
                    end
                end
                if (!(filt_en && tag_dup) && tag_cnt_r < maxtags_r)
                begin
                    tag_report <= 1'b1;
                    tag_cnt_r  <= tag_cnt_r + 10'h001;
                end
            end
            else if (tag_read_fail)
            begin
                hit_r <= 8'h00;
                if (tag_present)
                begin
                    miss_r <= miss_r + 8'h01;
                    if (miss_r + 8'h01 >= reread_r)
                    begin
                        tag_present <= 1'b0;
                        tag_depart  <= 1'b1;
                        miss_r      <= 8'h00;
                    end
                end
            end
        end
    end

endmodule // rfid_framing

// ### verification/rfid_framing_assertions.sv
// port checker of the reader framing block
`timescale 1ns/1ps
module rfid_framing_assertions (
    // clock and reset
    input wire       clk_sys,
    input wire       reset,
    // bus
    input wire       avs_read,
    input wire       avs_write,
    input wire       avs_waitrequest,
    // outputs watched
    input wire       cmd_good,
    input wire       cmd_bad,
    input wire [3:0] ant_select,
    input wire [3:0] ant_power,
    input wire       tag_present,
    input wire       tag_arrive,
    input wire       tag_depart,
    input wire [4:0] user_len,
    input wire [3:0] tid_len,
    input wire [5:0] epc_addr_bytes,
    input wire [5:0] epc_blk_bytes
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_rot;
        $changed(ant_select);
    endsequence
    a_bus_wait: assert property (s_req |=> !avs_waitrequest)
        else $error("bus access not answered");
    a_bus_stall: assert property ($rose(avs_read) |-> avs_waitrequest)
        else $error("read answered without wait");
    a_ant_order: assert property (s_rot |-> ant_select == {$past(ant_select[2:0]), $past(ant_select[3])})
        else $error("antenna order broken");
    a_ant_onehot: assert property ($onehot(ant_select))
        else $error("antenna select not one hot");
    a_power_sel: assert property ((ant_power & ~ant_select) == 4'h0)
        else $error("unselected antenna powered");
    a_user_len: assert property (user_len inside {[5'h01:5'h10]})
        else $error("user length out of range");
    a_tid_len: assert property (tid_len inside {[4'h2:4'hC]})
        else $error("tid length out of range");
    a_epc_pair: assert property ({epc_addr_bytes, epc_blk_bytes} inside {12'h40C, 12'hFBE})
        else $error("epc widths mismatched");
    a_arrive_set: assert property (tag_arrive |-> tag_present)
        else $error("arrival without presence");
    a_depart_clr: assert property (tag_depart |-> !tag_present)
        else $error("departure with presence");
    a_one_end: assert property (!(cmd_good && cmd_bad))
        else $error("telegram both good and bad");
endmodule // rfid_framing_assertions

// ### verification/host_uart_model.sv
// host side serial model: sends telegram bytes, collects reply bytes
`timescale 1ns/1ps
module host_uart_model #(
    parameter BIT = 16
) (
    // clock
    input  wire clk_sys,
    // serial pins
    input  wire uart_txd,
    output reg  uart_rxd
);
    reg [7:0] q [$];
    reg [7:0] d;
    initial uart_rxd = 1'b1;
    // start, 8 data lsb first, one stop, no parity
    task send(input [7:0] b);
        reg [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            uart_rxd <= f[i];
            repeat (BIT) @(posedge clk_sys);
        end
    endtask
    // reply bytes sampled mid bit
    always @(negedge uart_txd)
    begin
        repeat (BIT / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk_sys);
            d[i] = uart_txd;
        end
        repeat (BIT) @(posedge clk_sys);
        q.push_back(d);
    end
endmodule // host_uart_model

// ### verification/test_rfid_framing.sv
// testbench of the reader framing block
`timescale 1ns/1ps
module test_rfid_framing;
    reg         clk_sys, reset, avs_read, avs_write;
    reg         tag_read_ok, tag_read_fail, tag_epc_long, tag_dup;
    reg  [5:0]  avs_address;
    reg  [31:0] avs_writedata, v;
    reg  [3:0]  tag_tid_len;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, uart_rxd, uart_txd, cmd_good, cmd_bad;
    wire        tag_present, tag_arrive, tag_depart, tag_report;
    wire [3:0]  ant_select, ant_power, chan_index, tid_len;
    wire [15:0] user_start;
    wire [4:0]  user_len;
    wire [5:0]  epc_addr_bytes, epc_blk_bytes;
    reg  [31:0] rv [7];
    int         n_fail, checked, i;
    rfid_framing #(.SEC_CYCLES(100), .DWELL_CYCLES(16)) DUT (.*);
    host_uart_model #(.BIT(16)) u_host (.*);
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task results;
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task to;
        n_fail++;
        results;
    endtask
    task chk(input string s, input [31:0] e, input [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task bus(input w, input [5:0] ad, input [31:0] d);
        int k;
        k = 0;
        avs_address <= ad;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (avs_waitrequest && k < 50);
        v = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest) to;
        @(posedge clk_sys);
    endtask
    task wrd(input [5:0] ad, input [31:0] d, input [31:0] e);
        bus(1'b1, ad, d);
        bus(1'b0, ad, 32'h0);
        chk("register", e, v);
    endtask
    task air(input o, input [3:0] t, input el);
        tag_read_ok <= o;
        tag_read_fail <= !o;
        tag_tid_len <= t;
        tag_epc_long <= el;
        @(posedge clk_sys);
        tag_read_ok <= 1'b0;
        tag_read_fail <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // ccitt polynomial 1021, msb first
    function [15:0] crc(input [15:0] c, input [7:0] d);
        for (int j = 7; j >= 0; j--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[j]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    task tele(input [7:0] x, input lf);
        reg [15:0] c;
        int k;
        c = crc(crc(16'h0000, 8'h43), 8'h53);
        u_host.send(8'h43);
        u_host.send(8'h53);
        u_host.send(lf ? 8'h0A : c[15:8] ^ x);
        u_host.send(lf ? 8'h0D : c[7:0]);
        k = 0;
        while (!(cmd_good || cmd_bad) && k < 2000)
        begin
            @(posedge clk_sys);
            k++;
        end
        if (k == 2000) to;
    endtask
    // the next command waits for the reply, a scaled command gap
    task reply(input int n, input [31:0] e);
        int k;
        k = 0;
        while (u_host.q.size() < n && k < 3000)
        begin
            @(posedge clk_sys);
            k++;
        end
        if (k == 3000) to;
        for (k = n - 1; k >= 0; k--)
            chk("reply", e[8*k+:8], u_host.q.pop_front());
    endtask
    task pwr(input [3:0] e);
        int k;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (ant_select != 4'h1 && k < 64);
        chk("power", e, ant_power);
    endtask
    initial
    begin
        reset = 1'b1;
        {avs_read, avs_write, tag_read_ok, tag_read_fail, tag_epc_long, tag_dup} = 6'h00;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        tag_tid_len = 4'hC;
        rv = '{32'h0, 32'h87A, 32'h5, 32'h80, 32'h5, 32'h8, 32'h1};
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk("user_len", 32'h10, user_len);
        chk("tid_len", 32'hC, tid_len);
        chk("epc", 32'h40C, {epc_addr_bytes, epc_blk_bytes});
        chk("ant", 32'h1, ant_select);
        chk("chan", 32'h3, chan_index);
        chk("ustart", 32'h0, user_start);
        for (i = 0; i < 7; i++)
        begin
            bus(1'b0, 6'(4 * i), 32'h0);
            chk("reset value", rv[i], v);
        end
        wrd(6'h20, 32'h0, 32'h1);
        wrd(6'h20, 32'h14, 32'h10);
        wrd(6'h24, 32'h1, 32'h2);
        wrd(6'h24, 32'hF, 32'hC);
        wrd(6'h3C, 32'h5, 32'h0);
        wrd(6'h00, 32'h10, 32'h10);
        chk("epc", 32'hFBE, {epc_addr_bytes, epc_blk_bytes});
        wrd(6'h00, 32'h0, 32'h0);
        wrd(6'h10, 32'h2, 32'h2);
        repeat (3) air(1'b1, 4'hA, 1'b0);
        chk("present", 32'h0, tag_present);
        repeat (3) air(1'b1, 4'hC, 1'b1);
        chk("present", 32'h0, tag_present);
        air(1'b1, 4'hC, 1'b0);
        chk("present", 32'h0, tag_present);
        air(1'b1, 4'hC, 1'b0);
        chk("present", 32'h1, tag_present);
        wrd(6'h04, 32'h10, 32'h10);
        tele(8'h00, 1'b0);
        chk("end", 32'h2, {cmd_good, cmd_bad});
        pwr(4'h1);
        reply(3, {8'h06, crc(16'h0000, 8'h06)});
        tele(8'h01, 1'b0);
        chk("end", 32'h1, {cmd_good, cmd_bad});
        reply(4, {16'h1501, crc(crc(16'h0000, 8'h15), 8'h01)});
        repeat (2) air(1'b0, 4'hC, 1'b0);
        chk("present", 32'h0, tag_present);
        wrd(6'h00, 32'h1, 32'h1);
        tele(8'h00, 1'b1);
        chk("end", 32'h2, {cmd_good, cmd_bad});
        reply(4, 32'h15020A0D);
        pwr(4'h0);
        results;
    end
endmodule // test_rfid_framing
bind rfid_framing rfid_framing_assertions u_chk (.*);
